//--- hdl/spec_regs.vh
// constants for the suspend, power-event and clock-stop control block
// assumes one 100 MHz clock and a plain strobe register port with 8-bit data
//
// Functional notes
// - falling external management input raises management interrupt
// - selected, enabled bus alert raises irq, mgmt or wake
// - lid rising, falling or both edges selectable
// - optional 200 us lid debounce
// - same enable debounces power button 200 us
// - primary plane off in POS, RAM, disk
// - secondary plane off in RAM, disk only
// - tertiary plane off in disk suspend only
// - host clock may stop in stop-clock and suspends
// - refresh clock runs, stopped in disk, soft-off
// - PCI reset at power-up or by software
// - slow clock active only for nonzero select code
// - CPU clock stop request output
// - PCI clock stop request output
// - resume reset clears all standby registers except gpo, which loads all ones
// - shared monitor pin is wake-on-LAN or thermal
// - shared pin is sleep button when bit clear
`ifndef SPEC_REGS_VH
`define SPEC_REGS_VH

// register byte addresses
`define SPEC_ADDR_CFG     8'h00
`define SPEC_ADDR_PINSEL  8'h04
`define SPEC_ADDR_CLKSEL  8'h08
`define SPEC_ADDR_CTRL    8'h0C
`define SPEC_ADDR_EVEN    8'h10
`define SPEC_ADDR_STATUS  8'h14
`define SPEC_ADDR_MASK    8'h18
`define SPEC_ADDR_INPUTS  8'h1C
`define SPEC_ADDR_GPO     8'h20

// configuration byte fields
`define SPEC_CFG_DEB_EN    5
`define SPEC_CFG_SLP_OFF   6
`define SPEC_CFG_WOL_SEL   7
// pin select fields
`define SPEC_PSEL_SLOW_LO  0
`define SPEC_PSEL_PRI      2
`define SPEC_PSEL_SEC      3
`define SPEC_PSEL_HOST     4
`define SPEC_PSEL_REFRESH  5
// clock stop select fields
`define SPEC_CSEL_CPU      0
`define SPEC_CSEL_PCI      1
// control fields
`define SPEC_CTRL_CPU_STOP 4
`define SPEC_CTRL_PCI_STOP 5
`define SPEC_CTRL_PCI_RST  6
// event enable fields
`define SPEC_EVEN_EXT      0
`define SPEC_EVEN_ALERT    1
`define SPEC_EVEN_LID_RISE 2
`define SPEC_EVEN_LID_FALL 3
`define SPEC_EVEN_ALERT_FN 4
`define SPEC_EVEN_ROUTE_LO 5
// status bits
`define SPEC_ST_EXT        0
`define SPEC_ST_ALERT      1
`define SPEC_ST_LID        2
`define SPEC_ST_POWER_BUTTON_N     3
`define SPEC_ST_SLEEP_BUTTON_N     4
`define SPEC_ST_WOL        5
`define SPEC_ST_THERM      6

// power states
`define SPEC_PS_ON         3'h0
`define SPEC_PS_STOPCLK    3'h1
`define SPEC_PS_POS        3'h2
`define SPEC_PS_RAM        3'h3
`define SPEC_PS_DISK       3'h4
`define SPEC_PS_SOFTOFF    3'h5

// alert routes
`define SPEC_ROUTE_IRQ     2'h0
`define SPEC_ROUTE_MGMT    2'h1
`define SPEC_ROUTE_PME     2'h2

// reset values
`define SPEC_RST_CFG       8'h00
`define SPEC_RST_PINSEL    8'h00
`define SPEC_RST_CLKSEL    8'h00
`define SPEC_RST_CTRL      8'h00
`define SPEC_RST_EVEN      8'h00
`define SPEC_RST_MASK      8'h00
`define SPEC_RST_GPO       8'hFF

// timing
`define SPEC_CLK_HZ        100000000
`define SPEC_DEB_TIME_US   200
`define SPEC_DEB_CYC       (`SPEC_DEB_TIME_US * (`SPEC_CLK_HZ / 1000000))
`define SPEC_REFRESH_HZ    32768
`define SPEC_REFRESH_HALF  (`SPEC_CLK_HZ / (2 * `SPEC_REFRESH_HZ))

`endif

//--- hdl/spec_suspend_power.v
// suspend-plane, power-event and clock-stop control
// assumes synchronous register strobes; event pins are asynchronous, the monitor pin idles low
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "spec_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module spec_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_arst_n,
  // data
  input  wire [WIDTH-1:0] i_d,
  output wire [WIDTH-1:0] o_q
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= RST_VAL;
      stable <= RST_VAL;
    end else begin
      meta   <= i_d;
      stable <= meta;
    end
  end

  assign o_q = stable;
endmodule

////////////////////////////////////////////////////////////////////////////////
module spec_debounce #(
  parameter LIMIT = 20000
) (
  // clock and reset
  input  wire i_clk,
  input  wire i_arst_n,
  // control and data
  input  wire i_en,
  input  wire i_in,
  output wire o_level
);
  reg        level;
  reg [14:0] cnt;

  // a level must hold LIMIT cycles before it is believed
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level <= 1'b1;
      cnt   <= 15'h0000;
    end else if (!i_en) begin
      level <= i_in;
      cnt   <= 15'h0000;
    end else if (i_in == level) begin
      cnt   <= 15'h0000;
    end else if (cnt >= LIMIT[14:0] - 15'h0001) begin
      level <= i_in;
      cnt   <= 15'h0000;
    end else begin
      cnt   <= cnt + 15'h0001;
    end
  end

  assign o_level = level;
endmodule

////////////////////////////////////////////////////////////////////////////////
module spec_suspend_power #(
  parameter DEB_CYCLES = `SPEC_DEB_CYC
) (
  // clock and resume reset
  input  wire       i_clk,
  input  wire       i_arst_n,
  // register port
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // event inputs
  input  wire       i_ext_mgmt_irq_n,
  input  wire       i_bus_alert_n,
  input  wire       i_lid,
  input  wire       i_power_button_n,
  input  wire       i_sleep_button_n,
  input  wire       i_monitor_in,
  input  wire       i_power_good,
  // interrupt outputs
  output wire       o_irq,
  output reg        o_mgmt_irq_out_n,
  output reg        o_pme_n,
  // plane and clock control outputs
  output reg        o_primary_plane_off_n,
  output reg        o_secondary_plane_off_n,
  output reg        o_tertiary_plane_off_n,
  output reg        o_host_clk_may_stop_n,
  output reg        o_refresh_slow_clk,
  output reg        o_selectable_slow_clk,
  output reg        o_pci_bus_reset_n,
  output reg        o_cpu_clk_stop_req_n,
  output reg        o_pci_clk_stop_req_n
);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0]  cfg;
  reg  [7:0]  pinsel;
  reg  [7:0]  clksel;
  reg  [7:0]  ctrl;
  reg  [7:0]  even;
  reg  [7:0]  status;
  reg  [7:0]  mask;
  reg  [7:0]  gpo;
  reg  [7:0]  next_rdata;
  reg  [7:0]  ev_set;
  wire [2:0]  pstate;
  wire [1:0]  route;
  wire [1:0]  slow_sel;

  assign pstate   = ctrl[2:0];
  assign route    = even[`SPEC_EVEN_ROUTE_LO+1:`SPEC_EVEN_ROUTE_LO];
  assign slow_sel = pinsel[`SPEC_PSEL_SLOW_LO+1:`SPEC_PSEL_SLOW_LO];

  //////////////////////////////////////////////////////////////////////////////
  // input conditioning
  wire [6:0] raw;
  wire [6:0] syn;
  wire       lid_lvl;
  wire       power_button_n_lvl;

  assign raw = {i_power_good, i_monitor_in, i_sleep_button_n, i_power_button_n,
                i_lid, i_bus_alert_n, i_ext_mgmt_irq_n};

  spec_sync #(
    .WIDTH   (7),
    .RST_VAL (7'h1F)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (raw),
    .o_q      (syn)
  );

  spec_debounce #(
    .LIMIT (DEB_CYCLES)
  ) u_deb_lid (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_en     (cfg[`SPEC_CFG_DEB_EN]),
    .i_in     (syn[2]),
    .o_level  (lid_lvl)
  );

  spec_debounce #(
    .LIMIT (DEB_CYCLES)
  ) u_deb_pwr (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_en     (cfg[`SPEC_CFG_DEB_EN]),
    .i_in     (syn[3]),
    .o_level  (power_button_n_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // edge detection
  reg [5:0] prev;
  wire [5:0] cur;

  assign cur = {syn[5], syn[4], power_button_n_lvl, lid_lvl, syn[1], syn[0]};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev <= 6'h1F;
    end else begin
      prev <= cur;
    end
  end

  always @* begin
    ev_set = 8'h00;
    // falling edge of external management input
    ev_set[`SPEC_ST_EXT] = even[`SPEC_EVEN_EXT] & prev[0] & ~cur[0];
    // alert asserted while function selected and enabled
    ev_set[`SPEC_ST_ALERT] = even[`SPEC_EVEN_ALERT_FN] & even[`SPEC_EVEN_ALERT] & ~cur[1];
    ev_set[`SPEC_ST_LID] = (even[`SPEC_EVEN_LID_RISE] & ~prev[2] & cur[2]) |
                           (even[`SPEC_EVEN_LID_FALL] & prev[2] & ~cur[2]);
    ev_set[`SPEC_ST_POWER_BUTTON_N] = prev[3] & ~cur[3];
    // sleep button only when its bit is clear
    ev_set[`SPEC_ST_SLEEP_BUTTON_N] = ~cfg[`SPEC_CFG_SLP_OFF] & prev[4] & ~cur[4];
    ev_set[`SPEC_ST_WOL]   = cfg[`SPEC_CFG_WOL_SEL] & ~prev[5] & cur[5];
    ev_set[`SPEC_ST_THERM] = ~cfg[`SPEC_CFG_WOL_SEL] & ~prev[5] & cur[5];
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes; resume reset clears everything here except gpo, which loads 8'hFF
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg    <= `SPEC_RST_CFG;
      pinsel <= `SPEC_RST_PINSEL;
      clksel <= `SPEC_RST_CLKSEL;
      ctrl   <= `SPEC_RST_CTRL;
      even   <= `SPEC_RST_EVEN;
      mask   <= `SPEC_RST_MASK;
      gpo    <= `SPEC_RST_GPO;
    end else if (i_wr) begin
      case (i_addr)
        `SPEC_ADDR_CFG: begin
          cfg <= i_wdata & 8'hE0;
        end
        `SPEC_ADDR_PINSEL: begin
          pinsel <= i_wdata & 8'h3F;
        end
        `SPEC_ADDR_CLKSEL: begin
          clksel <= i_wdata & 8'h03;
        end
        `SPEC_ADDR_CTRL: begin
          ctrl <= i_wdata & 8'h77;
        end
        `SPEC_ADDR_EVEN: begin
          even <= i_wdata & 8'h7F;
        end
        `SPEC_ADDR_MASK: begin
          mask <= i_wdata & 8'h7F;
        end
        `SPEC_ADDR_GPO: begin
          gpo <= i_wdata & 8'h3F;
        end
        default: begin
          cfg <= cfg;
        end
      endcase
    end
  end

  // sticky status, write one to clear; a same-cycle event survives the clear
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status <= 8'h00;
    end else if (i_wr && i_addr == `SPEC_ADDR_STATUS) begin
      status <= (status & ~i_wdata) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port, data valid only in the cycle after the strobe
  always @* begin
    case (i_addr)
      `SPEC_ADDR_CFG:    next_rdata = cfg;
      `SPEC_ADDR_PINSEL: next_rdata = pinsel;
      `SPEC_ADDR_CLKSEL: next_rdata = clksel;
      `SPEC_ADDR_CTRL:   next_rdata = ctrl;
      `SPEC_ADDR_EVEN:   next_rdata = even;
      `SPEC_ADDR_STATUS: next_rdata = status;
      `SPEC_ADDR_MASK:   next_rdata = mask;
      `SPEC_ADDR_INPUTS: next_rdata = {1'b0, syn[6], cur};
      `SPEC_ADDR_GPO:    next_rdata = gpo;
      default:           next_rdata = 8'h00;
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt outputs
  wire [7:0] pend;
  wire       alert_pend;

  assign pend       = status & mask;
  assign alert_pend = pend[`SPEC_ST_ALERT];
  assign o_irq      = |pend;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mgmt_irq_out_n <= 1'b1;
      o_pme_n          <= 1'b1;
    end else begin
      // management interrupt from pin, lid, button, wake-on-LAN and thermal events
      // alert goes where the route field sends it
      o_mgmt_irq_out_n <= ~((|(pend & 8'h7D)) | (alert_pend & (route == `SPEC_ROUTE_MGMT)));
      o_pme_n          <= ~(alert_pend & (route == `SPEC_ROUTE_PME));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // suspend clock and slow clock dividers
  reg [10:0] half_cnt;
  reg        refresh_phase;
  reg [2:0]  slow_cnt;
  wire       half_tick;
  wire       refresh_stop;

  assign half_tick    = (half_cnt == `SPEC_REFRESH_HALF - 1);
  assign refresh_stop = (pstate == `SPEC_PS_DISK) || (pstate == `SPEC_PS_SOFTOFF);

  // the divider rounds down, so the refresh clock runs a little fast
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      half_cnt      <= 11'h000;
      refresh_phase <= 1'b0;
      slow_cnt      <= 3'h0;
    end else if (half_tick) begin
      half_cnt      <= 11'h000;
      refresh_phase <= ~refresh_phase;
      slow_cnt      <= slow_cnt + 3'h1;
    end else begin
      half_cnt      <= half_cnt + 11'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // plane, clock and reset outputs; select bit set hands the pin to gpo
  wire in_pos;
  wire in_ram;
  wire in_disk;
  wire pwr_good;

  assign in_pos   = (pstate == `SPEC_PS_POS);
  assign in_ram   = (pstate == `SPEC_PS_RAM);
  assign in_disk  = (pstate == `SPEC_PS_DISK);
  assign pwr_good = syn[6];

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_primary_plane_off_n   <= 1'b1;
      o_secondary_plane_off_n <= 1'b1;
      o_tertiary_plane_off_n  <= 1'b1;
      o_host_clk_may_stop_n   <= 1'b1;
      o_refresh_slow_clk      <= 1'b0;
      o_selectable_slow_clk   <= 1'b0;
      o_pci_bus_reset_n       <= 1'b0;
      o_cpu_clk_stop_req_n    <= 1'b1;
      o_pci_clk_stop_req_n    <= 1'b1;
    end else begin
      o_primary_plane_off_n <= pinsel[`SPEC_PSEL_PRI] ? gpo[0] : ~(in_pos | in_ram | in_disk);
      o_secondary_plane_off_n <= pinsel[`SPEC_PSEL_SEC] ? gpo[1] : ~(in_ram | in_disk);
      o_tertiary_plane_off_n <= ~in_disk;
      o_host_clk_may_stop_n <= pinsel[`SPEC_PSEL_HOST] ? gpo[2] :
                               ~((pstate == `SPEC_PS_STOPCLK) | in_pos | in_ram | in_disk);
      // refresh clock gated in disk and off states
      o_refresh_slow_clk <= pinsel[`SPEC_PSEL_REFRESH] ? gpo[3] : (refresh_phase & ~refresh_stop);
      // slow clock halves per code step
      case (slow_sel)
        2'h1:    o_selectable_slow_clk <= slow_cnt[0];
        2'h2:    o_selectable_slow_clk <= slow_cnt[1];
        2'h3:    o_selectable_slow_clk <= slow_cnt[2];
        default: o_selectable_slow_clk <= 1'b0;
      endcase
      o_pci_bus_reset_n <= pwr_good & ~ctrl[`SPEC_CTRL_PCI_RST];
      o_cpu_clk_stop_req_n <= clksel[`SPEC_CSEL_CPU] ? gpo[4] :
                              ~(ctrl[`SPEC_CTRL_CPU_STOP] | (pstate == `SPEC_PS_STOPCLK));
      o_pci_clk_stop_req_n <= clksel[`SPEC_CSEL_PCI] ? gpo[5] : ~ctrl[`SPEC_CTRL_PCI_STOP];
    end
  end

endmodule

//--- bench/spec_sva.sv
// assertion checker for the suspend, power-event and clock-stop block
// assumes it is bound to the top module; register state is shadowed from the write port
`timescale 1ns/1ps
module spec_sva #(
  parameter DEB_CYCLES = 20000
) (
  // clock, reset and register port
  input wire       i_clk,
  input wire       i_arst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  // events and outputs
  input wire       i_ext_mgmt_irq_n,
  input wire       o_irq,
  input wire       o_mgmt_irq_out_n,
  input wire       o_primary_plane_off_n,
  input wire       o_secondary_plane_off_n,
  input wire       o_tertiary_plane_off_n,
  input wire       o_pci_bus_reset_n,
  input wire       o_cpu_clk_stop_req_n,
  input wire       o_pci_clk_stop_req_n
);
  reg  [7:0] ctl, psl, csl, evn, msk;
  wire [2:0] ps = ctl[2:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // outputs are registered, so the shadow must hold one cycle before they are judged
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {ctl, psl, csl, evn, msk} <= 40'h0;
    end else if (i_wr) begin
      case (i_addr)
        8'h04: psl <= i_wdata;
        8'h08: csl <= i_wdata;
        8'h0C: ctl <= i_wdata;
        8'h10: evn <= i_wdata;
        8'h18: msk <= i_wdata;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////
  a_primary_off: assert property (!psl[2] && $stable(psl) && $stable(ctl) |->
    o_primary_plane_off_n == !(ps inside {3'h2, 3'h3, 3'h4})) else $error("primary plane level wrong");
  a_secondary_off: assert property (!psl[3] && $stable(psl) && $stable(ctl) |->
    o_secondary_plane_off_n == !(ps inside {3'h3, 3'h4})) else $error("secondary plane level wrong");
  a_tertiary_off: assert property ($stable(ctl) |-> o_tertiary_plane_off_n == (ps != 3'h4))
    else $error("tertiary plane level wrong");
  a_pci_reset_sw: assert property (ctl[6] [*2] |-> !o_pci_bus_reset_n)
    else $error("pci reset not held by software");
  a_cpu_stop_req: assert property (!csl[0] && $stable(csl) && $stable(ctl) |->
    o_cpu_clk_stop_req_n == !(ctl[4] || ps == 3'h1)) else $error("cpu stop request wrong");
  a_pci_stop_req: assert property (!csl[1] && $stable(csl) && $stable(ctl) |->
    o_pci_clk_stop_req_n == !ctl[5]) else $error("pci stop request wrong");
  a_ext_event: assert property (evn[0] && msk[0] && $fell(i_ext_mgmt_irq_n) |->
    ##[2:5] !o_mgmt_irq_out_n) else $error("external event gave no management interrupt");
  a_irq_masked: assert property (msk == 8'h00 |-> !o_irq)
    else $error("interrupt raised while fully masked");
endmodule

bind spec_suspend_power spec_sva #(.DEB_CYCLES(DEB_CYCLES)) u_sva (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_ext_mgmt_irq_n(i_ext_mgmt_irq_n), .o_irq(o_irq), .o_mgmt_irq_out_n(o_mgmt_irq_out_n),
  .o_primary_plane_off_n(o_primary_plane_off_n), .o_secondary_plane_off_n(o_secondary_plane_off_n),
  .o_tertiary_plane_off_n(o_tertiary_plane_off_n), .o_pci_bus_reset_n(o_pci_bus_reset_n),
  .o_cpu_clk_stop_req_n(o_cpu_clk_stop_req_n), .o_pci_clk_stop_req_n(o_pci_clk_stop_req_n));

//--- bench/spec_partner.sv
// supply model: the main rail follows the tertiary plane control
// assumes the bench clock; a supply has no reset of its own
`timescale 1ns/1ps
module spec_partner #(
  parameter PG_DELAY = 16
) (
  input  wire i_clk,
  input  wire i_tertiary_plane_off_n,
  output reg  o_power_good
);
  int cnt = 0;
  initial o_power_good = 1'h0;
  always @(posedge i_clk) begin
    if (!i_tertiary_plane_off_n) begin
      cnt <= 0;
      o_power_good <= 1'h0;
    end else if (cnt < PG_DELAY) begin
      cnt <= cnt + 1;
    end else begin
      o_power_good <= 1'h1;
    end
  end
endmodule

//--- bench/spec_suspend_power_bench.sv
// self-checking bench for the suspend, power-event and clock-stop block
// assumes the design, partner and checker sources are compiled before it
`timescale 1ns/1ps
`include "spec_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module spec_suspend_power_bench;
  localparam int HALF = `SPEC_REFRESH_HALF;
  logic       clk    = 1'h0;
  logic       arst_n = 1'h0;
  logic [7:0] addr   = 8'h00;
  logic [7:0] wd     = 8'h00;
  logic       wr     = 1'h0;
  logic       rd     = 1'h0;
  // ext, alert, lid, power, sleep idle high; monitor idle low
  logic [5:0] pins   = 6'h1F;
  wire  [7:0] rdata;
  wire        irq, mgmt, pme, pri, sec, ter, host, rclk, sclk, prst, cst, pst, pgood;
  int         bad_count    = 0;
  int         total_checks = 0;
  int         seed         = 32'hE2DD;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h2C};
  // config, enables, pin, pulse length (0 leaves it toggled), expected status
  logic [39:0] tbl [21] = '{
    40'h00_01_00_03_01, 40'h00_00_00_03_00, 40'h00_12_01_03_02, 40'h00_32_01_03_02, 40'h00_52_01_03_02,
    40'h00_02_01_03_00, 40'h00_08_02_00_04, 40'h00_08_02_00_00, 40'h00_04_02_00_00, 40'h00_04_02_00_04,
    40'h00_0C_02_00_04, 40'h00_0C_02_00_04, 40'h20_0C_02_04_00, 40'h20_0C_02_14_04, 40'h00_00_03_02_08,
    40'h20_00_03_04_00, 40'h20_00_03_14_08, 40'h00_00_04_02_10, 40'h40_00_04_02_00, 40'h80_00_05_02_20,
    40'h00_00_05_02_40};

  spec_suspend_power #(.DEB_CYCLES(8)) DUT (
    .i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_ext_mgmt_irq_n(pins[0]), .i_bus_alert_n(pins[1]), .i_lid(pins[2]), .i_power_button_n(pins[3]),
    .i_sleep_button_n(pins[4]), .i_monitor_in(pins[5]), .i_power_good(pgood), .o_irq(irq),
    .o_mgmt_irq_out_n(mgmt), .o_pme_n(pme), .o_primary_plane_off_n(pri), .o_secondary_plane_off_n(sec),
    .o_tertiary_plane_off_n(ter), .o_host_clk_may_stop_n(host), .o_refresh_slow_clk(rclk),
    .o_selectable_slow_clk(sclk), .o_pci_bus_reset_n(prst), .o_cpu_clk_stop_req_n(cst),
    .o_pci_clk_stop_req_n(pst));
  spec_partner u_supply (.i_clk(clk), .i_tertiary_plane_off_n(ter), .o_power_good(pgood));

  always #5 clk = ~clk;
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic togs(input int n, output int ta, output int tb);
    logic pa, pb;
    #1;
    ta = 0;
    tb = 0;
    pa = rclk;
    pb = sclk;
    repeat (n) begin
      @(posedge clk);
      #1;
      ta += (rclk !== pa);
      tb += (sclk !== pb);
      pa = rclk;
      pb = sclk;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    logic [7:0]  v, r;
    logic [39:0] t;
    int          s, ta, tb;
    tick(20);
    arst_n <= 1'h1;
    wreg(8'h2C, 8'hFF);
    for (s = 0; s < 9; s++) begin
      rreg(ra[s], v);
      `CHK("reset value", (ra[s] == 8'h20) ? 8'hFF : 8'h00, v)
    end
    rreg(8'h1C, v);
    `CHK("inputs idle", 8'h5F, v)
    repeat (4) begin
      v = 8'($random(seed));
      wreg(8'h18, v);
      rreg(8'h18, r);
      `CHK("mask", v & 8'h7F, r)
    end
    for (s = 0; s < 6; s++) begin
      wreg(8'h0C, 8'(s));
      tick(4);
      togs(2 * HALF + 100, ta, tb);
      `CHK("primary", !(s inside {2, 3, 4}), pri)
      `CHK("secondary", !(s inside {3, 4}), sec)
      `CHK("tertiary", s != 4, ter)
      `CHK("host stop", !(s inside {1, 2, 3, 4}), host)
      `CHK("refresh runs", !(s inside {4, 5}), ta > 0)
      `CHK("pci reset", s != 4, prst)
      `CHK("cpu stop", s != 1, cst)
    end
    wreg(8'h0C, 8'h30);
    tick(3);
    `CHK("cpu stop sw", 1'h0, cst)
    `CHK("pci stop sw", 1'h0, pst)
    wreg(8'h0C, 8'h40);
    tick(3);
    `CHK("pci reset sw", 1'h0, prst)
    `CHK("pci stop off", 1'h1, pst)
    wreg(8'h08, 8'h03);
    wreg(8'h0C, 8'h30);
    tick(3);
    `CHK("cpu stop gpo", 1'h1, cst)
    wreg(8'h04, 8'h04);
    wreg(8'h20, 8'h00);
    tick(3);
    `CHK("primary gpo", 1'h0, pri)
    wreg(8'h08, 8'h00);
    wreg(8'h0C, 8'h00);
    // slowest code waits two full periods of a quarter-rate clock
    for (s = 0; s < 4; s++) begin
      wreg(8'h04, 8'(s));
      tick(4);
      togs((2 * HALF << s) + 100, ta, tb);
      `CHK("slow clock", s != 0, tb > 0)
    end
    wreg(8'h18, 8'h7F);
    for (s = 0; s < 21; s++) begin
      t = tbl[s];
      wreg(8'h00, t[39:32]);
      wreg(8'h10, t[31:24]);
      pins[t[18:16]] <= ~pins[t[18:16]];
      if (t[15:8] != 8'h00) begin
        tick(t[15:8]);
        pins[t[18:16]] <= ~pins[t[18:16]];
      end
      tick(30);
      `CHK("mgmt", !(t[7:0] != 0 && (t[18:16] != 1 || t[30:29] == 1)), mgmt)
      if (t[18:16] == 3'h1) `CHK("pme", !(t[7:0] != 0 && t[30:29] == 2), pme)
      `CHK("irq", t[7:0] != 0, irq)
      rreg(8'h14, v);
      `CHK("status", t[7:0], v)
      wreg(8'h14, 8'hFF);
    end
    wreg(8'h10, 8'h5A);
    arst_n <= 1'h0;
    tick(2);
    arst_n <= 1'h1;
    rreg(8'h10, v);
    `CHK("enables after reset", 8'h00, v)
    wrap_up();
  end
endmodule
